// >>> core/pfc_ctrl.sv
module pfc_ctrl
  import pfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [pfc_pkg::FA_W-1:0] flash_addr_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic write_n_o,
  output logic reset_powerdown_n_o,
  output logic write_permit_o,
  output logic word_mode_o,
  output logic reset_high_level_o,
  output logic id_override_level_o,
  input wire logic [pfc_pkg::LANE_W-1:0] low_data_lane_i,
  output logic [pfc_pkg::LANE_W-1:0] low_data_lane_o,
  output logic low_data_lane_oe_o,
  input wire logic [pfc_pkg::HI_W-1:0] high_data_lane_i,
  output logic [pfc_pkg::HI_W-1:0] high_data_lane_o,
  output logic high_data_lane_oe_o,
  input wire logic top_data_or_byte_lsb_i,
  output logic top_data_or_byte_lsb_o,
  output logic top_data_or_byte_lsb_oe_o
);
  import pfc_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_SETUP = 5'h02, S_PULSE = 5'h04,
    S_HOLD = 5'h08, S_GAP = 5'h10
  } pfc_state_t;

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  logic [DATA_W-1:0] pin_s;

  pfc_sync #(.W(DATA_W)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .en_i(en_i),
    .d_i({top_data_or_byte_lsb_i, high_data_lane_i, low_data_lane_i}),
    .q_o(pin_s)
  );

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [31:0] rdata_bus_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic stale_r, stale_nxt;
  pfc_state_t state_r, state_nxt;
  logic start_c;

  // Writes while busy are dropped so an operation sees stable values
  assign start_c = reg_wr_i && reg_addr_i == REG_CMD &&
                   state_r == S_IDLE && ctrl_r[CTRL_RUN];

  always_comb begin
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdata_bus_nxt = reg_rdata_o;
    if (reg_wr_i && state_r == S_IDLE) begin
      unique case (reg_addr_i)
        REG_CTRL: ctrl_nxt = reg_wdata_i[3:0];
        REG_ADDR: addr_nxt = reg_wdata_i[ADDR_W-1:0];
        REG_WDATA: wdata_nxt = reg_wdata_i[DATA_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: rdata_bus_nxt = {28'h0, ctrl_r};
        REG_ADDR: rdata_bus_nxt = {12'h0, addr_r};
        REG_WDATA: rdata_bus_nxt = {16'h0, rdata_r};
        REG_CMD: rdata_bus_nxt = {30'h0, stale_r, state_r != S_IDLE};
        default: rdata_bus_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= CTRL_RESET;
      addr_r <= '0;
      wdata_r <= '0;
      reg_rdata_o <= 32'h0;
    end else if (en_i) begin
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      reg_rdata_o <= rdata_bus_nxt;
    end
  end

  // Level pins follow the control register directly
  // boot permit
  assign write_permit_o = ctrl_r[CTRL_WP];
  assign reset_high_level_o = ctrl_r[CTRL_VHH];
  assign word_mode_o = ctrl_r[CTRL_WORD];
  assign reset_powerdown_n_o = ctrl_r[CTRL_RUN];

  // ----------------------------------------
  // Bus cycle engine
  // ----------------------------------------
  pfc_op_t op_r, op_nxt;
  logic step_r, step_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic load_c, wr_c, cmd_c, id_c;
  logic [DATA_W-1:0] dat_c;
  logic ce_n_nxt, oe_n_nxt, we_n_nxt, lo_oe_nxt, hi_oe_nxt, top_oe_nxt;
  logic top_nxt, vid_nxt;
  logic [FA_W-1:0] fa_nxt;
  logic [LANE_W-1:0] lo_nxt;
  logic [HI_W-1:0] hi_nxt;
  logic cur_wr_c;

  // Cycle in flight decoded from registered op; avoids reading a late value
  always_comb begin
    cur_wr_c = 1'b1;
    unique case (op_r)
      OP_READ, OP_IDCMD: cur_wr_c = !step_r;
      OP_IDVID: cur_wr_c = 1'b0;
      default: ;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    stale_nxt = stale_r;
    rdata_nxt = rdata_r;
    load_c = 1'b0;
    ce_n_nxt = chip_sel_n_o;
    oe_n_nxt = out_en_n_o;
    we_n_nxt = write_n_o;
    lo_oe_nxt = low_data_lane_oe_o;
    hi_oe_nxt = high_data_lane_oe_o;
    top_oe_nxt = top_data_or_byte_lsb_oe_o;
    top_nxt = top_data_or_byte_lsb_o;
    vid_nxt = id_override_level_o;
    fa_nxt = flash_addr_o;
    lo_nxt = low_data_lane_o;
    hi_nxt = high_data_lane_o;
    unique case (state_r)
      S_IDLE: begin
        if (start_c) begin
          op_nxt = pfc_op_t'(reg_wdata_i[OP_MSB:OP_LSB]);
          step_nxt = !(op_nxt == OP_PROG || op_nxt == OP_ERASE ||
                       op_nxt == OP_IDCMD ||
                       (op_nxt == OP_READ && stale_r));
          load_c = op_nxt != OP_NONE;
          if (!load_c) begin
            op_nxt = op_r;
          end
        end
      end
      S_SETUP: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == '0) begin
          state_nxt = S_PULSE;
          we_n_nxt = !cur_wr_c;
          oe_n_nxt = cur_wr_c;
          cnt_nxt = cur_wr_c ? CNT_W'(WE_CYC - 1) : CNT_W'(RD_CYC - 1);
        end
      end
      S_PULSE: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == '0) begin
          state_nxt = S_HOLD;
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          cnt_nxt = CNT_W'(HOLD_CYC - 1);
          if (!cur_wr_c) begin
            rdata_nxt = ctrl_r[CTRL_WORD] ? pin_s :
                        {8'h00, pin_s[LANE_W-1:0]};
          end
        end
      end
      S_HOLD: begin
        cnt_nxt = cnt_r - 1'b1;
        if (cnt_r == '0) begin
          ce_n_nxt = 1'b1;
          lo_oe_nxt = 1'b0;
          hi_oe_nxt = 1'b0;
          top_oe_nxt = 1'b0;
          vid_nxt = 1'b0;
          cnt_nxt = CNT_W'(GAP_CYC - 1);
          state_nxt = step_r ? S_IDLE : S_GAP;
          step_nxt = 1'b1;
          if (step_r) begin
            unique case (op_r)
              OP_PROG, OP_ERASE, OP_IDCMD: stale_nxt = 1'b1;
              OP_RAW: stale_nxt = wdata_r[LANE_W-1:0] != CMD_READ_ARRAY;
              OP_IDVID: stale_nxt = stale_r;
              default: stale_nxt = 1'b0;
            endcase
          end else if (op_r == OP_READ) begin
            // Prefix written: the read that follows sees the array
            stale_nxt = 1'b0;
          end
        end
      end
      S_GAP: begin
        cnt_nxt = cnt_r - 1'b1;
        load_c = cnt_r == '0;
      end
      default: state_nxt = S_IDLE;
    endcase
    if (!ctrl_r[CTRL_RUN]) begin
      stale_nxt = 1'b0;
    end

    wr_c = 1'b1;
    id_c = 1'b0;
    dat_c = {8'h00, CMD_READ_ARRAY};
    unique case (op_nxt)
      OP_PROG: dat_c = step_nxt ? wdata_r : {8'h00, CMD_WRITE_SETUP};
      OP_ERASE: dat_c = {8'h00, step_nxt ? CMD_ERASE_CONFIRM :
                                           CMD_ERASE_SETUP};
      OP_READ: wr_c = !step_nxt;
      OP_IDCMD: begin
        wr_c = !step_nxt;
        id_c = step_nxt;
        dat_c = {8'h00, CMD_IDENTIFY};
      end
      OP_IDVID: begin
        wr_c = 1'b0;
        id_c = 1'b1;
      end
      OP_RAW: dat_c = {8'h00, wdata_r[LANE_W-1:0]};
      default: ;
    endcase
    cmd_c = !(op_nxt == OP_PROG && step_nxt);

    if (load_c) begin
      state_nxt = S_SETUP;
      cnt_nxt = CNT_W'(SETUP_CYC - 1);
      ce_n_nxt = 1'b0;
      fa_nxt = id_c ? {{(FA_W-1){1'b0}}, addr_r[1]} : addr_r[ADDR_W-1:1];
      vid_nxt = op_nxt == OP_IDVID;
      lo_oe_nxt = wr_c;
      lo_nxt = dat_c[LANE_W-1:0];
      // upper lane only in word mode data writes
      hi_oe_nxt = wr_c && !cmd_c && ctrl_r[CTRL_WORD];
      hi_nxt = dat_c[TOP_BIT-1:LANE_W];
      top_oe_nxt = !ctrl_r[CTRL_WORD] || (wr_c && !cmd_c);
      top_nxt = ctrl_r[CTRL_WORD] ? dat_c[TOP_BIT] : addr_r[0];
    end
  end

  // Pins come straight from flops; data stays driven past strobe rise
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= S_IDLE;
      op_r <= OP_NONE;
      step_r <= 1'b0;
      cnt_r <= '0;
      stale_r <= 1'b0;
      rdata_r <= '0;
      chip_sel_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      write_n_o <= 1'b1;
      low_data_lane_oe_o <= 1'b0;
      high_data_lane_oe_o <= 1'b0;
      top_data_or_byte_lsb_oe_o <= 1'b0;
      top_data_or_byte_lsb_o <= 1'b0;
      id_override_level_o <= 1'b0;
      flash_addr_o <= '0;
      low_data_lane_o <= '0;
      high_data_lane_o <= '0;
    end else if (en_i) begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      stale_r <= stale_nxt;
      rdata_r <= rdata_nxt;
      chip_sel_n_o <= ce_n_nxt;
      out_en_n_o <= oe_n_nxt;
      write_n_o <= we_n_nxt;
      low_data_lane_oe_o <= lo_oe_nxt;
      high_data_lane_oe_o <= hi_oe_nxt;
      top_data_or_byte_lsb_oe_o <= top_oe_nxt;
      top_data_or_byte_lsb_o <= top_nxt;
      id_override_level_o <= vid_nxt;
      flash_addr_o <= fa_nxt;
      low_data_lane_o <= lo_nxt;
      high_data_lane_o <= hi_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_strobe_clash: assert property (
    !(!write_n_o && !out_en_n_o)) else $error("both strobes low");
  a_byte_lsb_pin: assert property (
    !chip_sel_n_o && !word_mode_o |-> top_data_or_byte_lsb_oe_o &&
    top_data_or_byte_lsb_o == addr_r[0]) else $error("byte lsb wrong");
  a_cmd_low_lane: assert property (
    $fell(write_n_o) && !(op_r == OP_PROG && step_r) |->
    !high_data_lane_oe_o) else $error("command on upper lane");
  a_erase_pair: assert property (
    $fell(write_n_o) && op_r == OP_ERASE |-> low_data_lane_o ==
    (step_r ? CMD_ERASE_CONFIRM : CMD_ERASE_SETUP))
    else $error("erase code wrong");
  a_prog_setup: assert property (
    $fell(write_n_o) && op_r == OP_PROG && !step_r |->
    low_data_lane_o == CMD_WRITE_SETUP ##[1:40] $fell(write_n_o) && step_r)
    else $error("program pair broken");
  a_array_fresh: assert property (
    $fell(out_en_n_o) && op_r == OP_READ |-> !stale_r)
    else $error("array read while stale");
  a_id_address: assert property (
    id_override_level_o |-> flash_addr_o[FA_W-1:1] == '0)
    else $error("id address not clear");
  a_vid_read: assert property (
    $rose(id_override_level_o) |-> write_n_o ##[1:8] $fell(out_en_n_o))
    else $error("id level without read");
endmodule

// >>> core/pfc_pkg.sv
package pfc_pkg;
  // ----------------------------------------
  // Software register map
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_CMD = 4'hC;
  localparam logic [3:0] REG_STATUS = 4'h0 + 4'h0 + 4'h0 + 4'h0 + 4'h0;
  localparam logic [3:0] REG_RDATA = 4'h4 + 4'h0;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WORD = 1;
  localparam int CTRL_WP = 2;
  localparam int CTRL_VHH = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam int ST_BUSY = 0;
  localparam int ST_STALE = 1;
  localparam int OP_LSB = 0;
  localparam int OP_MSB = 2;
  localparam int LANE_W = 8;
  localparam int HI_W = 7;
  localparam int FA_W = 19;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int TOP_BIT = 15;
  // ----------------------------------------
  // Operations and device command codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROG = 3'h1, OP_ERASE = 3'h2, OP_RDARR = 3'h3,
    OP_IDCMD = 3'h4, OP_IDVID = 3'h5, OP_RAW = 3'h6, OP_NONE = 3'h7
  } pfc_op_t;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  // Identify code not fixed here; plain default
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  // ----------------------------------------
  // Pin timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SETUP_NS = 20;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_ACCESS_NS = 100;
  localparam int T_HOLD_NS = 10;
  localparam int T_GAP_NS = 20;
  localparam int SYNC_STAGES = 2;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = ACC_CYC + SYNC_STAGES + 1;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 5;
endpackage

// >>> core/pfc_sync.sv
module pfc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else if (en_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// >>> tb/pfc_ctrl_bench.sv
module pfc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pfc_pkg::*;
  // Identification values are arbitrary
  localparam logic [7:0] MFR_C = 8'h5A;
  localparam logic [7:0] DEV_C = 8'hA1;
  localparam logic [7:0] HI_M = 8'h11;
  localparam logic [7:0] HI_D = 8'h22;
  typedef struct {logic [31:0] v; logic [31:0] m; string n;} pfc_note_t;
  pfc_note_t notes_q[$];
  pfc_note_t nt;
  logic clk_i = 0, reset_n_i = 0, wr = 0, rd = 0, rd_q = 0, flt = 0;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  wire logic [31:0] rdo;
  wire logic [18:0] fa;
  wire logic ce_n, oe_n, we_n, rp_n, wp, wm, vh, idl;
  wire logic lo_oe, hi_oe, tp_o, tp_oe, d_lo_oe, d_hi_oe;
  wire logic [7:0] lo_o;
  wire logic [6:0] hi_o;
  wire logic [15:0] d_o;
  // Released lanes toggle so stale data never looks valid
  wire logic [7:0] lo_w = lo_oe ? lo_o : d_lo_oe ? d_o[7:0] : {8{flt}};
  wire logic [6:0] hi_w = hi_oe ? hi_o : d_hi_oe ? d_o[14:8] : {7{flt}};
  wire logic tp_w = tp_oe ? tp_o : d_hi_oe ? d_o[15] : flt;
  int miscompares = 0, checks_done = 0, seed = 59, cyc = 0;

  pfc_ctrl pfc_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(1'b1),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdo), .flash_addr_o(fa), .chip_sel_n_o(ce_n),
    .out_en_n_o(oe_n), .write_n_o(we_n), .reset_powerdown_n_o(rp_n),
    .write_permit_o(wp), .word_mode_o(wm), .reset_high_level_o(vh),
    .id_override_level_o(idl), .low_data_lane_i(lo_w),
    .low_data_lane_o(lo_o), .low_data_lane_oe_o(lo_oe),
    .high_data_lane_i(hi_w), .high_data_lane_o(hi_o),
    .high_data_lane_oe_o(hi_oe), .top_data_or_byte_lsb_i(tp_w),
    .top_data_or_byte_lsb_o(tp_o), .top_data_or_byte_lsb_oe_o(tp_oe));
  pfc_flash_model #(.TOP_BOOT(1'b1), .MFR_CODE(MFR_C), .DEV_TOP(DEV_C),
    .HI_MFR(HI_M), .HI_DEV(HI_D)) pfc_flash_model_i (.ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n), .wp_i(wp), .vhh_i(vh),
    .word_i(wm), .id_lvl_i(idl), .addr_i(fa), .dq_i({tp_w, hi_w, lo_w}),
    .dq_o(d_o), .lo_oe_o(d_lo_oe), .hi_oe_o(d_hi_oe));

  initial forever #4 clk_i = ~clk_i;

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e,
                        input logic [31:0] m, input string n);
    notes_q.push_back('{e, m, n});
    @(posedge clk_i);
    rd <= 1'b1;
    ra <= a;
    @(posedge clk_i);
    rd <= 1'b0;
  endtask
  task automatic wait_idle();
    int n = 0;
    do begin
      rd_reg(REG_CMD, 32'h0, 32'h0, "poll");
      @(negedge clk_i);
      n++;
    end while (rdo[ST_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) cmp("busy_wait", 32'h0, 32'h1);
  endtask
  task automatic run_op(input logic [19:0] a, input logic [15:0] d,
                        input pfc_op_t o);
    wr_reg(REG_ADDR, {12'h0, a});
    wr_reg(REG_WDATA, {16'h0, d});
    wr_reg(REG_CMD, {29'h0, o});
    wait_idle();
  endtask
  task automatic chk_read(input logic [19:0] a, input logic [15:0] e,
                          input string n);
    run_op(a, 16'h0, OP_READ);
    rd_reg(REG_WDATA, {16'h0, e}, 32'hFFFF, n);
  endtask

  // ----------------------------------------
  // Result watcher and hang guard
  // ----------------------------------------
  always @(posedge clk_i) begin
    rd_q <= rd;
    flt <= ~flt;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  always @(negedge clk_i) begin
    cmp("lane_clash", 32'h0, {31'h0, lo_oe & d_lo_oe});
    cmp("hi_lane_byte", 32'h0, {31'h0, hi_oe & ~wm});
    cmp("top_clash", 32'h0, {31'h0, tp_oe & d_hi_oe});
    cmp("idle_float", 32'h0, {31'h0, ce_n & (lo_oe | hi_oe | tp_oe)});
    if (rd_q) begin
      nt = notes_q.pop_front();
      if (nt.m != 32'h0) cmp(nt.n, nt.v & nt.m, rdo & nt.m);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [18:0] w;
    logic [15:0] d;
    logic [19:0] a;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_reg(REG_CTRL, 32'h1, 32'hF, "ctrl_rst");
    rd_reg(REG_CMD, 32'h0, 32'h3, "stat_rst");
    rd_reg(4'h2, 32'h0, 32'hFFFFFFFF, "unmapped");
    wr_reg(REG_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      w = {2'b01, 2'(i), 15'($random(seed))};
      d = 16'($random(seed));
      run_op({w, 1'b0}, d, OP_PROG);
      rd_reg(REG_CMD, 32'h2, 32'h3, "stale");
      chk_read({w, 1'b0}, d, "word_rd");
    end
    run_op({w, 1'b0}, 16'h0, OP_ERASE);
    chk_read({w, 1'b0}, 16'hFFFF, "erased");
    wr_reg(REG_CTRL, 32'h1);
    a = {4'h2, 15'($random(seed)), 1'b1};
    run_op(a, {8'h0, d[7:0]}, OP_PROG);
    chk_read(a, {8'h00, d[7:0]}, "byte_rd");
    chk_read(a ^ 20'h1, 16'h00FF, "byte_other");
    wr_reg(REG_CTRL, 32'h3);
    a = {6'h3F, 13'($random(seed)), 1'b0};
    run_op(a, d, OP_PROG);
    chk_read(a, 16'hFFFF, "boot_locked");
    wr_reg(REG_CTRL, 32'h7);
    run_op(a, d, OP_PROG);
    chk_read(a, d, "boot_wp");
    wr_reg(REG_CTRL, 32'hB);
    run_op(a, 16'h0, OP_ERASE);
    chk_read(a, 16'hFFFF, "boot_vhh");
    for (int k = 0; k < 8; k++) begin
      wr_reg(REG_CTRL, k[2] ? 32'h3 : 32'h1);
      run_op({18'h0, k[0], 1'b0}, 16'h0, k[1] ? OP_IDVID : OP_IDCMD);
      d = {k[2] ? (k[0] ? HI_D : HI_M) : 8'h00, k[0] ? DEV_C : MFR_C};
      rd_reg(REG_WDATA, {16'h0, d}, 32'hFFFF, "id");
    end
    run_op(20'h0, {8'h0, CMD_IDENTIFY}, OP_RAW);
    rd_reg(REG_CMD, 32'h2, 32'h3, "raw_stale");
    wr_reg(REG_CMD, {29'h0, OP_NONE});
    rd_reg(REG_CMD, 32'h2, 32'h3, "op_none");
    run_op(20'h0, 16'h0, OP_RDARR);
    rd_reg(REG_CMD, 32'h0, 32'h3, "rd_array");
    wr_reg(REG_CMD, {29'h0, OP_READ});
    wr_reg(REG_CTRL, 32'h7);
    wait_idle();
    rd_reg(REG_CTRL, 32'h3, 32'hF, "busy_drop");
    wr_reg(REG_CTRL, 32'h0);
    wr_reg(REG_CMD, {29'h0, OP_PROG});
    rd_reg(REG_CMD, 32'h0, 32'h3, "run_off");
    rd_reg(REG_CTRL, 32'h0, 32'hF, "ctrl_off");
    give_verdict();
  end
endmodule

// >>> tb/pfc_flash_model.sv
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter logic TOP_BOOT = 1'b1,
  // Identification values are arbitrary
  parameter logic [7:0] MFR_CODE = 8'h5A,
  parameter logic [7:0] DEV_TOP = 8'hA1,
  parameter logic [7:0] DEV_BOT = 8'hA2,
  parameter logic [7:0] HI_MFR = 8'h11,
  parameter logic [7:0] HI_DEV = 8'h22
) (
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rp_n_i,
  input wire logic wp_i,
  input wire logic vhh_i,
  input wire logic word_i,
  input wire logic id_lvl_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic lo_oe_o,
  output logic hi_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  typedef enum logic [2:0] {FM_ARR, FM_ID, FM_STAT, FM_ERS, FM_PRG} pfc_fm_t;
  pfc_fm_t mode = FM_ARR;
  logic [15:0] mem [int];
  logic [19:0] a_q = 20'h0;
  logic [18:0] w;
  logic [15:0] old;
  logic ok;

  function automatic logic [15:0] rdv(input logic [18:0] a, input logic t,
                                      input pfc_fm_t md, input logic il,
                                      input logic wm);
    logic [15:0] v;
    v = mem.exists(a) ? mem[a] : 16'hFFFF;
    if (md == FM_STAT) v = 16'h0080;
    else if ((md == FM_ID || il) && (a & ~19'h00201) == 19'h0)
      v = a[0] ? {HI_DEV, TOP_BOOT ? DEV_TOP : DEV_BOT} : {HI_MFR, MFR_CODE};
    else if (!wm) v = {8'h00, t ? v[15:8] : v[7:0]};
    return v;
  endfunction

  always @(negedge we_n_i)
    if (!ce_n_i) a_q = {addr_i, word_i ? 1'b0 : dq_i[15]};
  always @(negedge rp_n_i) mode = FM_ARR;
  always @(posedge we_n_i) begin
    if (rp_n_i && !ce_n_i) begin
      w = a_q[19:1];
      old = mem.exists(w) ? mem[w] : 16'hFFFF;
      ok = (TOP_BOOT ? w[18:13] != 6'h3F : w[18:13] != 6'h00) || wp_i || vhh_i;
      case (mode)
        FM_PRG: begin
          if (ok && word_i) mem[w] = old & dq_i;
          else if (ok) mem[w] = old & (a_q[0] ? {dq_i[7:0], 8'hFF}
                                               : {8'hFF, dq_i[7:0]});
          mode = FM_STAT;
        end
        FM_ERS: begin
          if (ok && dq_i[7:0] == CMD_ERASE_CONFIRM)
            foreach (mem[k]) if (k[18:13] == w[18:13]) mem[k] = 16'hFFFF;
          mode = FM_STAT;
        end
        default: case (dq_i[7:0])
          CMD_ERASE_SETUP: mode = FM_ERS;
          8'h10, CMD_WRITE_SETUP: mode = FM_PRG;
          CMD_READ_ARRAY: mode = FM_ARR;
          CMD_IDENTIFY: mode = FM_ID;
          default: mode = FM_STAT;
        endcase
      endcase
    end
  end
  // drive only on a selected read
  assign lo_oe_o = rp_n_i && !ce_n_i && !oe_n_i && we_n_i;
  // upper lane in word mode only
  assign hi_oe_o = lo_oe_o && word_i;
  assign dq_o = rdv(addr_i, dq_i[15], mode, id_lvl_i, word_i);
endmodule
